// ===== mrra_pkg.sv
// Package of constants for the nibble register file and RAM addressing block.
package mrra_pkg;
    // Register bus geometry.
    localparam int REG_ADDR_W = 5;
    localparam int NIB_W = 4;
    localparam int BYTE_W = 8;
    // Register indices on the nibble-wide register port.
    localparam logic [4:0] OFF_ACC = 5'h00;
    localparam logic [4:0] OFF_AUX = 5'h01;
    localparam logic [4:0] OFF_PTR = 5'h02;
    localparam logic [4:0] OFF_PTRCTL = 5'h03;
    localparam logic [4:0] OFF_BANK = 5'h04;
    localparam logic [4:0] OFF_RPAGE = 5'h05;
    localparam logic [4:0] OFF_PPAGE = 5'h06;
    localparam logic [4:0] OFF_STATUS_ONE = 5'h07;
    localparam logic [4:0] OFF_SCTL = 5'h08;
    localparam logic [4:0] OFF_WAKEA = 5'h09;
    localparam logic [4:0] OFF_WAKEB = 5'h0A;
    localparam logic [4:0] OFF_PIN_STROBE_STATUS = 5'h0B;
    localparam logic [4:0] OFF_TMR2 = 5'h0C;
    localparam logic [4:0] OFF_SIO = 5'h0D;
    localparam logic [4:0] OFF_DISP = 5'h0E;
    localparam logic [4:0] OFF_SP = 5'h0F;
    // Field positions.
    localparam int PTRCTL_EN_BIT = 0;
    localparam int SCTL_ICLK_BIT = 0;
    localparam int SCTL_HIZ_BIT = 1;
    localparam int SCTL_FUNC_BIT = 2;
    localparam int SCTL_START_BIT = 3;
    localparam int PIN_STROBE_STATUS_INT_BIT = 2;
    localparam int PIN_STROBE_STATUS_STB_BIT = 3;
    // Addressing modes presented with an address request.
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_BANK = 2'h1;
    localparam logic [1:0] MODE_IMMPTR = 2'h2;
    // Reset values.
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [1:0] RST_PAGE = 2'h0;
    localparam logic [3:0] RST_SP = 4'h1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [13:0] RST_RET = 14'h0000;
    // Stack geometry: entries, word width and the pointer limits.
    localparam int STACK_DEPTH = 8;
    localparam int RET_W = 14;
    localparam logic [3:0] SP_FULL = 4'h9;
    localparam logic [3:0] SP_ONE = 4'h1;
    localparam logic [3:0] SP_TWO = 4'h2;
    // Segment strobe index below which the strobe flag reads as one.
    localparam logic [4:0] STROBE_LIMIT = 5'h10;
endpackage : mrra_pkg

// ===== mrra_core.sv
// Register file, RAM address former and return stack of the 4-bit core.
//
// Contract
// [RQ1] Direct mode takes the full 8-bit operand as the in-page RAM address.
// [RQ2] Pointer-eligible instructions use pointer high and low halves while pointer enabled.
// [RQ3] Pointer high half equal to bank falls back to the immediate operand.
// [RQ4] Pointer acts as address only while its enable flag is set.
// [RQ5] Return stack holds eight 14-bit entries, eight levels deep.
// [RQ6] Stack pointer increments on call/interrupt, decrements on return/pop, resets to one.
// [RQ7] Bank register is 4 bits, used for bank addressing, reset to zero.
// [RQ8] RAM page field is 2 bits, reset to zero.
// [RQ9] Two 8-bit down timers, each loadable with 8 bits at once.
// [RQ10] Second timer low nibble via data port, high nibble via auxiliary register.
// [RQ11] Serial shift counter low nibble via data port, high via auxiliary register.
// [RQ12] Auxiliary register pairs with a nibble for display, timer, serial, pointer.
// [RQ13] Program page field is 2 bits, reset to zero.
// [RQ14] Serial control holds clock source, output high-impedance and pin function bits.
// [RQ15] Software sets transfer start; device holds it low while transfer runs.
// [RQ16] Two read-only wake cause registers report what ended halt or stop.
// [RQ17] Status five bits zero and one read zero; one bit shows interrupt pin.
// [RQ18] Strobe flag is one for index 00 to 0F, zero for 10 to 1E.
// [RQ19] Display pins all on or all off in reset by option; outputs high.
// [RQ20] Bank, page and status registers reset to zero.
// [RQ21] Bank mode address is bank as high nibble, operand as low nibble.
// [RQ22] Final RAM address is page field joined to in-page address.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ns
module mrra_core
    import mrra_pkg::*;
#(
    parameter bit SEG_RESET_ON = 1'b0,
    parameter int SEG_PINS = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [4:0] regAddr,
    input wire logic [3:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [3:0] regRdata,
    input wire logic addrReq,
    input wire logic [1:0] addrMode,
    input wire logic [7:0] addrOperand,
    output logic [9:0] ramAddr,
    output logic ramAddrValid,
    output logic pointerUsed,
    input wire logic pushReq,
    input wire logic [13:0] pushAddr,
    input wire logic popReq,
    output logic [13:0] returnAddr,
    output logic [3:0] stackPointer,
    input wire logic [1:0] timerLoad,
    input wire logic [7:0] timerImm,
    input wire logic [1:0] timerTick,
    output logic [7:0] firstDownTimer,
    output logic [7:0] secondDownTimer,
    input wire logic serialShift,
    input wire logic serialBitIn,
    input wire logic serialBusy,
    output logic [7:0] serialShiftCounter,
    output logic [3:0] serialControlStatus,
    output logic [1:0] programPageSelect,
    input wire logic [3:0] statusOneIn,
    input wire logic wakeEvent,
    input wire logic [3:0] wakeCauseA,
    input wire logic [3:0] wakeCauseB,
    input wire logic interruptPin,
    input wire logic [4:0] segStrobeIndex,
    output logic [SEG_PINS-1:0] segDrive
);
    logic [3:0] accumulatorNibble;
    logic [3:0] auxNibble;
    logic [3:0] pointerLowHalf;
    logic [3:0] pointerHighHalf;
    logic pointerEnableFlag;
    logic [3:0] ramBankSelect;
    logic [1:0] ramPageSelect;
    logic [3:0] statusOne;
    logic [3:0] wakeStatusA;
    logic [3:0] wakeStatusB;
    logic [3:0] pinStrobeStatus;
    logic intSync1;
    logic intSync2;
    logic [13:0] stackMem [STACK_DEPTH];
    logic [7:0] timerCount [2];
    logic [7:0] next_inPage;
    logic next_ptrUsed;
    logic [3:0] next_rdata;
    logic wrHit;
    logic rdHit;

    assign wrHit = regWr;
    assign rdHit = regRd;
    assign firstDownTimer = timerCount[0];
    assign secondDownTimer = timerCount[1];

    // Plain data registers written straight from the register port.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accumulatorNibble <= RST_NIB;
            pointerEnableFlag <= 1'b0;
            ramBankSelect <= RST_NIB; // [RQ7] [RQ20]
            ramPageSelect <= RST_PAGE; // [RQ8]
            programPageSelect <= RST_PAGE; // [RQ13]
        end else if (wrHit) begin
            case (regAddr)
                OFF_ACC: accumulatorNibble <= regWdata;
                OFF_PTRCTL: pointerEnableFlag <= regWdata[PTRCTL_EN_BIT];
                OFF_BANK: ramBankSelect <= regWdata;
                OFF_RPAGE: ramPageSelect <= regWdata[1:0];
                OFF_PPAGE: programPageSelect <= regWdata[1:0];
                default: ;
            endcase
        end
    end

    // Auxiliary nibble: written directly, and loaded with the high half on a paired read.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            auxNibble <= RST_NIB;
        end else if (wrHit && regAddr == OFF_AUX) begin
            auxNibble <= regWdata;
        end else if (rdHit) begin
            case (regAddr)
                OFF_PTR: auxNibble <= pointerHighHalf; // [RQ12]
                OFF_TMR2: auxNibble <= timerCount[1][7:4]; // [RQ10]
                OFF_SIO: auxNibble <= serialShiftCounter[7:4]; // [RQ11]
                default: ;
            endcase
        end
    end

    // Pointer is loaded as a pair: low from the port, high from the auxiliary nibble.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pointerLowHalf <= RST_NIB;
            pointerHighHalf <= RST_NIB;
        end else if (wrHit && regAddr == OFF_PTR) begin
            pointerLowHalf <= regWdata; // [RQ12]
            pointerHighHalf <= auxNibble;
        end
    end

    // Display latch holds the reset pattern until software writes a byte pair.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            segDrive <= {SEG_PINS{SEG_RESET_ON}}; // [RQ19]
        end else if (wrHit && regAddr == OFF_DISP) begin
            segDrive <= SEG_PINS'({auxNibble, regWdata}); // [RQ12]
        end
    end

    // In-page address selection for each addressing mode.
    always_comb begin
        next_inPage = addrOperand; // [RQ1]
        next_ptrUsed = 1'b0;
        case (addrMode)
            MODE_BANK: next_inPage = {ramBankSelect, addrOperand[3:0]}; // [RQ21]
            MODE_IMMPTR: begin
                if (pointerEnableFlag && pointerHighHalf != ramBankSelect) begin // [RQ2] [RQ3] [RQ4]
                    next_inPage = {pointerHighHalf, pointerLowHalf};
                    next_ptrUsed = 1'b1;
                end
            end
            default: next_inPage = addrOperand;
        endcase
    end

    // Registered RAM address, valid one cycle after the request.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ramAddr <= '0;
            ramAddrValid <= 1'b0;
            pointerUsed <= 1'b0;
        end else begin
            ramAddrValid <= addrReq;
            if (addrReq) begin
                ramAddr <= {ramPageSelect, next_inPage}; // [RQ22]
                pointerUsed <= next_ptrUsed;
            end
        end
    end

    // Return stack pointer; pushes beyond eight levels and pops below one are ignored.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stackPointer <= RST_SP; // [RQ6]
            returnAddr <= RST_RET;
        end else if (pushReq && stackPointer != SP_FULL) begin
            stackPointer <= stackPointer + SP_ONE; // [RQ6]
        end else if (popReq && stackPointer != SP_ONE) begin
            stackPointer <= stackPointer - SP_ONE; // [RQ6]
            returnAddr <= stackMem[3'(stackPointer - SP_TWO)];
        end
    end

    // Stack storage: eight 14-bit words, no reset needed.
    always_ff @(posedge core_clk) begin
        if (pushReq && stackPointer != SP_FULL) begin
            stackMem[3'(stackPointer - SP_ONE)] <= pushAddr; // [RQ5]
        end
    end

    // Both down timers; the second also takes a byte pair from the register port.
    generate
        for (genvar t = 0; t < 2; t++) begin : gTimer
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    timerCount[t] <= RST_BYTE;
                end else if (timerLoad[t]) begin
                    timerCount[t] <= timerImm; // [RQ9]
                end else if (t == 1 && wrHit && regAddr == OFF_TMR2) begin
                    timerCount[t] <= {auxNibble, regWdata}; // [RQ10]
                end else if (timerTick[t]) begin
                    timerCount[t] <= timerCount[t] - 8'h01; // [RQ9]
                end
            end
        end
    endgenerate

    // Serial shift counter: byte pair write or shift of one bit in at the bottom.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serialShiftCounter <= RST_BYTE;
        end else if (wrHit && regAddr == OFF_SIO) begin
            serialShiftCounter <= {auxNibble, regWdata}; // [RQ11]
        end else if (serialShift) begin
            serialShiftCounter <= {serialShiftCounter[6:0], serialBitIn};
        end
    end

    // Serial control: three selections plus the start flag that running clears.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serialControlStatus <= RST_NIB; // [RQ20]
        end else begin
            if (wrHit && regAddr == OFF_SCTL) begin
                serialControlStatus[SCTL_FUNC_BIT:SCTL_ICLK_BIT] <= regWdata[2:0]; // [RQ14]
            end
            if (serialBusy) begin
                serialControlStatus[SCTL_START_BIT] <= 1'b0; // [RQ15]
            end else if (wrHit && regAddr == OFF_SCTL) begin
                serialControlStatus[SCTL_START_BIT] <= regWdata[SCTL_START_BIT]; // [RQ15]
            end
        end
    end

    // Interrupt pin passes two flip-flops before it is read.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            intSync1 <= 1'b0;
            intSync2 <= 1'b0;
        end else begin
            intSync1 <= interruptPin;
            intSync2 <= intSync1;
        end
    end

    // Read-only status captures: status one, wake causes and status five.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            statusOne <= RST_NIB;
            wakeStatusA <= RST_NIB; // [RQ20]
            wakeStatusB <= RST_NIB;
            pinStrobeStatus <= RST_NIB;
        end else begin
            statusOne <= statusOneIn;
            if (wakeEvent) begin
                wakeStatusA <= wakeCauseA; // [RQ16]
                wakeStatusB <= wakeCauseB; // [RQ16]
            end
            pinStrobeStatus <= {segStrobeIndex < STROBE_LIMIT, intSync2, 2'b00}; // [RQ17] [RQ18]
        end
    end

    // Read multiplexer; unmapped indices read zero.
    always_comb begin
        case (regAddr)
            OFF_ACC: next_rdata = accumulatorNibble;
            OFF_AUX: next_rdata = auxNibble;
            OFF_PTR: next_rdata = pointerLowHalf;
            OFF_PTRCTL: next_rdata = {3'b000, pointerEnableFlag};
            OFF_BANK: next_rdata = ramBankSelect;
            OFF_RPAGE: next_rdata = {2'b00, ramPageSelect};
            OFF_PPAGE: next_rdata = {2'b00, programPageSelect};
            OFF_STATUS_ONE: next_rdata = statusOne;
            OFF_SCTL: next_rdata = serialControlStatus;
            OFF_WAKEA: next_rdata = wakeStatusA;
            OFF_WAKEB: next_rdata = wakeStatusB;
            OFF_PIN_STROBE_STATUS: next_rdata = pinStrobeStatus;
            OFF_TMR2: next_rdata = timerCount[1][3:0];
            OFF_SIO: next_rdata = serialShiftCounter[3:0];
            OFF_SP: next_rdata = stackPointer;
            default: next_rdata = RST_NIB;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= RST_NIB;
        end else begin
            regRdata <= rdHit ? next_rdata : RST_NIB;
        end
    end

    // Checks on addressing, stack, timers, pairing and status.
    direct_addr_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ1]
        addrReq && addrMode == MODE_DIRECT |=> ramAddr[7:0] == $past(addrOperand) && !pointerUsed)
        else $error("Direct address not taken from operand.");
    pointer_addr_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ2]
        addrReq && addrMode == MODE_IMMPTR && pointerEnableFlag
        && pointerHighHalf != ramBankSelect
        |=> ramAddr[7:0] == {$past(pointerHighHalf), $past(pointerLowHalf)})
        else $error("Pointer address not formed from pointer halves.");
    pointer_clash_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ3]
        addrReq && addrMode == MODE_IMMPTR && pointerHighHalf == ramBankSelect
        |=> ramAddr[7:0] == $past(addrOperand) && !pointerUsed)
        else $error("Clashing pointer did not fall back to immediate.");
    pointer_off_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ4]
        addrReq && !pointerEnableFlag |=> !pointerUsed)
        else $error("Pointer used while disabled.");
    bank_addr_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ21]
        addrReq && addrMode == MODE_BANK
        |=> ramAddr[7:0] == {$past(ramBankSelect), $past(addrOperand[3:0])})
        else $error("Bank address wrongly formed.");
    page_join_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ22]
        addrReq |=> ramAddrValid && ramAddr[9:8] == $past(ramPageSelect))
        else $error("Page field not joined to address.");
    stack_push_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ6]
        pushReq && stackPointer != SP_FULL |=> stackPointer == $past(stackPointer) + SP_ONE)
        else $error("Stack pointer did not increment.");
    stack_round_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ5]
        pushReq && !popReq && stackPointer != SP_FULL ##1 popReq && !pushReq
        |=> returnAddr == $past(pushAddr, 2))
        else $error("Popped address differs from pushed one.");
    timer_load_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ9]
        timerLoad[1] ##1 !timerLoad[1] && timerTick[1] && !wrHit
        |=> secondDownTimer == $past(timerImm, 2) - 8'h01)
        else $error("Timer did not load and count down.");
    timer_pair_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ10]
        wrHit && regAddr == OFF_TMR2 && !timerLoad[1]
        |=> secondDownTimer == {$past(auxNibble), $past(regWdata)})
        else $error("Timer pair write wrong.");
    start_busy_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ15]
        serialBusy |=> !serialControlStatus[SCTL_START_BIT])
        else $error("Start flag high while transfer runs.");
    status_five_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ17]
        pinStrobeStatus[1:0] == 2'b00 && pinStrobeStatus[PIN_STROBE_STATUS_INT_BIT] == $past(intSync2))
        else $error("Status five low bits or pin level wrong.");
    strobe_flag_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ18]
        ##1 pinStrobeStatus[PIN_STROBE_STATUS_STB_BIT] == ($past(segStrobeIndex) <= 5'h0F))
        else $error("Strobe flag wrong for index.");
    wake_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ16]
        wakeEvent ##1 !wakeEvent |-> wakeStatusA == $past(wakeCauseA, 1))
        else $error("Wake cause not captured.");
    stack_pop_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ6]
        popReq && !pushReq && stackPointer != SP_ONE |=> stackPointer == $past(stackPointer) - SP_ONE)
        else $error("Stack pointer did not decrement.");
    stack_full_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ5]
        pushReq && stackPointer == SP_FULL |=> stackPointer == SP_FULL)
        else $error("Stack grew beyond eight levels.");
    bank_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ7]
        wrHit && regAddr == OFF_BANK |=> ramBankSelect == $past(regWdata))
        else $error("Bank register write lost.");
    page_write_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ8]
        wrHit && regAddr == OFF_RPAGE |=> ramPageSelect == $past(regWdata[1:0]))
        else $error("RAM page write lost.");
    serial_pair_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ11]
        wrHit && regAddr == OFF_SIO |=> serialShiftCounter == {$past(auxNibble), $past(regWdata)})
        else $error("Serial counter pair write wrong.");
    aux_load_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RQ10]
        rdHit && regAddr == OFF_TMR2 |=> auxNibble == $past(secondDownTimer[7:4]))
        else $error("Timer high nibble not loaded into auxiliary register.");
endmodule : mrra_core

// ===== tb.sv
// Self-checking testbench for the nibble register file, RAM address former and return stack.
`timescale 1ns/1ns
module tb
    import mrra_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [3:0] regWdata = 4'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [3:0] regRdata;
    logic addrReq = 1'b0;
    logic [1:0] addrMode = 2'h0;
    logic [7:0] addrOperand = 8'h00;
    logic [9:0] ramAddr;
    logic ramAddrValid;
    logic pointerUsed;
    logic pushReq = 1'b0;
    logic [13:0] pushAddr = 14'h0000;
    logic popReq = 1'b0;
    logic [13:0] returnAddr;
    logic [3:0] stackPointer;
    logic [1:0] timerLoad = 2'h0;
    logic [7:0] timerImm = 8'h00;
    logic [1:0] timerTick = 2'h0;
    logic [7:0] firstDownTimer;
    logic [7:0] secondDownTimer;
    logic serialShift = 1'b0;
    logic serialBitIn = 1'b0;
    logic serialBusy = 1'b0;
    logic [7:0] serialShiftCounter;
    logic [3:0] serialControlStatus;
    logic [1:0] programPageSelect;
    logic [3:0] statusOneIn = 4'h0;
    logic wakeEvent = 1'b0;
    logic [3:0] wakeCauseA = 4'h0;
    logic [3:0] wakeCauseB = 4'h0;
    logic interruptPin = 1'b0;
    logic [4:0] segStrobeIndex = 5'h10;
    logic [7:0] segDrive;
    int miscompares = 0;
    int nCompared = 0;

    // The clock toggles every half period of 4 ns.
    always #4 core_clk = ~core_clk;

    mrra_core u_mrra_core (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .addrReq(addrReq), .addrMode(addrMode), .addrOperand(addrOperand), .ramAddr(ramAddr),
        .ramAddrValid(ramAddrValid), .pointerUsed(pointerUsed), .pushReq(pushReq),
        .pushAddr(pushAddr), .popReq(popReq), .returnAddr(returnAddr),
        .stackPointer(stackPointer), .timerLoad(timerLoad), .timerImm(timerImm),
        .timerTick(timerTick), .firstDownTimer(firstDownTimer),
        .secondDownTimer(secondDownTimer), .serialShift(serialShift),
        .serialBitIn(serialBitIn), .serialBusy(serialBusy),
        .serialShiftCounter(serialShiftCounter), .serialControlStatus(serialControlStatus),
        .programPageSelect(programPageSelect), .statusOneIn(statusOneIn),
        .wakeEvent(wakeEvent), .wakeCauseA(wakeCauseA), .wakeCauseB(wakeCauseB),
        .interruptPin(interruptPin), .segStrobeIndex(segStrobeIndex), .segDrive(segDrive));

    // Prints the verdict once and ends the run.
    task automatic wrap_up();
        if (miscompares == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    // One-cycle register write; returns once its updates have landed.
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    // One-cycle register read; the nibble is checked in the following cycle only.
    task automatic rd(input logic [4:0] a, input logic [3:0] exp);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("regRdata at %h", a), 16'(exp), 16'(regRdata));
    endtask : rd

    // Address request, then the formed address, valid pulse and pointer use are checked.
    task automatic rq(input logic [1:0] m, input logic [7:0] op, input logic [9:0] ea,
                      input logic ep);
        @(posedge core_clk);
        addrReq <= 1'b1;
        addrMode <= m;
        addrOperand <= op;
        @(posedge core_clk);
        addrReq <= 1'b0;
        #1;
        chk("ramAddrValid", 16'h0001, 16'(ramAddrValid));
        chk("ramAddr", 16'(ea), 16'(ramAddr));
        chk("pointerUsed", 16'(ep), 16'(pointerUsed));
    endtask : rq

    // Push or pop one stack word and check the pointer afterwards.
    task automatic stk(input logic push, input logic [13:0] a, input logic [3:0] esp);
        @(posedge core_clk);
        pushReq <= push;
        popReq <= ~push;
        pushAddr <= a;
        @(posedge core_clk);
        pushReq <= 1'b0;
        popReq <= 1'b0;
        #1;
        chk("stackPointer", 16'(esp), 16'(stackPointer));
        if (!push) begin
            chk("returnAddr", 16'(a), 16'(returnAddr));
        end
    endtask : stk

    // Watchdog cuts a hang short well beyond the expected run length.
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end

    // Main sequence of register, addressing, stack, timer and status tests.
    initial begin
        repeat (3) @(posedge core_clk);
        chk("sp in reset", 16'h0001, 16'(stackPointer));
        chk("segDrive in reset", 16'h0000, 16'(segDrive));
        nrst <= 1'b1;
        rd(OFF_BANK, 4'h0);
        rd(OFF_RPAGE, 4'h0);
        rd(OFF_PPAGE, 4'h0);
        rd(OFF_SCTL, 4'h0);
        rd(OFF_PIN_STROBE_STATUS, 4'h0);
        rd(5'h1F, 4'h0);
        wr(OFF_ACC, 4'h7);
        rd(OFF_ACC, 4'h7);
        wr(OFF_RPAGE, 4'h1);
        rq(MODE_DIRECT, 8'hA5, 10'h1A5, 1'b0);
        wr(OFF_BANK, 4'h6);
        rq(MODE_BANK, 8'h05, 10'h165, 1'b0);
        wr(OFF_AUX, 4'h5);
        wr(OFF_PTR, 4'h3);
        wr(OFF_PTRCTL, 4'h1);
        wr(OFF_BANK, 4'h4);
        rq(MODE_IMMPTR, 8'h10, 10'h153, 1'b1);
        rq(MODE_DIRECT, 8'h10, 10'h110, 1'b0);
        wr(OFF_BANK, 4'h5);
        rq(MODE_IMMPTR, 8'h10, 10'h110, 1'b0);
        wr(OFF_BANK, 4'h4);
        wr(OFF_PTRCTL, 4'h0);
        rq(MODE_IMMPTR, 8'h10, 10'h110, 1'b0);
        for (int i = 0; i < 9; i++) begin
            stk(1'b1, 14'h3FF0 | 14'(i), (i < 8) ? 4'(i + 2) : 4'h9);
        end
        for (int i = 7; i >= -1; i--) begin
            stk(1'b0, 14'h3FF0 | 14'((i >= 0) ? i : 0), (i >= 0) ? 4'(i + 1) : 4'h1);
        end
        // A push followed at once by a pop returns the pushed word.
        @(posedge core_clk);
        pushReq <= 1'b1;
        pushAddr <= 14'h2A5C;
        @(posedge core_clk);
        pushReq <= 1'b0;
        popReq <= 1'b1;
        @(posedge core_clk);
        popReq <= 1'b0;
        #1;
        chk("returnAddr back to back", 16'h2A5C, 16'(returnAddr));
        @(posedge core_clk);
        timerLoad <= 2'h3;
        timerImm <= 8'hA7;
        @(posedge core_clk);
        timerLoad <= 2'h0;
        timerTick <= 2'h1;
        @(posedge core_clk);
        timerTick <= 2'h0;
        #1;
        chk("firstDownTimer", 16'h00A6, 16'(firstDownTimer));
        chk("secondDownTimer", 16'h00A7, 16'(secondDownTimer));
        // The second timer alone is loaded and then counts down once.
        @(posedge core_clk);
        timerLoad <= 2'h2;
        timerImm <= 8'h3C;
        @(posedge core_clk);
        timerLoad <= 2'h0;
        timerTick <= 2'h2;
        @(posedge core_clk);
        timerTick <= 2'h0;
        #1;
        chk("secondDownTimer tick", 16'h003B, 16'(secondDownTimer));
        chk("firstDownTimer held", 16'h00A6, 16'(firstDownTimer));
        wr(OFF_AUX, 4'h9);
        wr(OFF_TMR2, 4'h2);
        chk("secondDownTimer pair", 16'h0092, 16'(secondDownTimer));
        wr(OFF_AUX, 4'h0);
        rd(OFF_TMR2, 4'h2);
        rd(OFF_AUX, 4'h9);
        wr(OFF_AUX, 4'h4);
        wr(OFF_SIO, 4'hE);
        chk("serialShiftCounter", 16'h004E, 16'(serialShiftCounter));
        @(posedge core_clk);
        serialShift <= 1'b1;
        serialBitIn <= 1'b1;
        @(posedge core_clk);
        serialShift <= 1'b0;
        #1;
        chk("serialShiftCounter shift", 16'h009D, 16'(serialShiftCounter));
        rd(OFF_SIO, 4'hD);
        rd(OFF_AUX, 4'h9);
        wr(OFF_AUX, 4'hA);
        wr(OFF_DISP, 4'h5);
        chk("segDrive", 16'h00A5, 16'(segDrive));
        wr(OFF_SCTL, 4'hF);
        chk("serialControlStatus", 16'h000F, 16'(serialControlStatus));
        @(posedge core_clk);
        serialBusy <= 1'b1;
        wr(OFF_SCTL, 4'hF);
        rd(OFF_SCTL, 4'h7);
        @(posedge core_clk);
        serialBusy <= 1'b0;
        wr(OFF_PPAGE, 4'h3);
        chk("programPageSelect", 16'h0003, 16'(programPageSelect));
        @(posedge core_clk);
        statusOneIn <= 4'hA;
        wakeCauseA <= 4'h3;
        wakeCauseB <= 4'hC;
        wakeEvent <= 1'b1;
        interruptPin <= 1'b1;
        segStrobeIndex <= 5'h0F;
        @(posedge core_clk);
        wakeEvent <= 1'b0;
        wakeCauseA <= 4'h0;
        wr(OFF_STATUS_ONE, 4'h5);
        rd(OFF_STATUS_ONE, 4'hA);
        wr(OFF_WAKEA, 4'h0);
        rd(OFF_WAKEA, 4'h3);
        rd(OFF_WAKEB, 4'hC);
        rd(OFF_PIN_STROBE_STATUS, 4'hC);
        @(posedge core_clk);
        interruptPin <= 1'b0;
        segStrobeIndex <= 5'h10;
        repeat (4) @(posedge core_clk);
        rd(OFF_PIN_STROBE_STATUS, 4'h0);
        stk(1'b1, 14'h0123, 4'h2);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rd(OFF_BANK, 4'h0);
        chk("sp after reset", 16'h0001, 16'(stackPointer));
        chk("segDrive after reset", 16'h0000, 16'(segDrive));
        wrap_up();
    end
endmodule : tb
